/* hdl/hoc_pkg.sv */
// holdover control bank: register indices, field layout, reset values, types
package hoc_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int HOC_LOOPS = 3;   // loop order everywhere: 0 = A, 1 = C, 2 = D
  localparam int HOC_AW    = 16;
  localparam int HOC_DW    = 32;
  localparam int HOC_NW    = 5;

  typedef logic [HOC_AW-3:0] hoc_idx_t;

  // ---------------------------------------------------------------
  // register indices (byte address = 4 x index)
  // ---------------------------------------------------------------
  localparam hoc_idx_t HOC_IDX_STATE  = 14'h000E;
  localparam hoc_idx_t HOC_IDX_STICKY = 14'h0013;
  localparam hoc_idx_t HOC_IDX_MASK   = 14'h0015;
  localparam hoc_idx_t HOC_IDX_EXIT  [HOC_LOOPS] = '{14'h042C, 14'h062C, 14'h072D};
  localparam hoc_idx_t HOC_IDX_WIN   [HOC_LOOPS] = '{14'h042E, 14'h062E, 14'h072F};
  localparam hoc_idx_t HOC_IDX_DLY   [HOC_LOOPS] = '{14'h042F, 14'h062F, 14'h0730};
  localparam hoc_idx_t HOC_IDX_FORCE [HOC_LOOPS] = '{14'h0435, 14'h0635, 14'h0736};
  localparam hoc_idx_t HOC_IDX_HIST  [HOC_LOOPS] = '{14'h043F, 14'h063F, 14'h0740};

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  // status, sticky and mask share one layout; bit 5 stays zero
  localparam int HOC_FLD_POS [HOC_LOOPS] = '{4, 6, 7};
  localparam int HOC_BW_BIT    = 4;
  localparam int HOC_RAMP_BIT  = 3;
  localparam int HOC_FORCE_BIT = 0;
  localparam int HOC_HIST_BIT  = 1;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic             HOC_BW_RST    = 1'b0;
  localparam logic             HOC_RAMP_RST  = 1'b1;
  localparam logic [HOC_NW-1:0] HOC_WIN_RST  = 5'h0A;
  localparam logic [HOC_NW-1:0] HOC_DLY_RST  = 5'h00;
  localparam logic             HOC_FORCE_RST = 1'b0;
  localparam logic [HOC_LOOPS-1:0] HOC_MASK_RST = 3'h0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    HOC_FREERUN,
    HOC_ACQUIRE,
    HOC_LOCKED,
    HOC_HOLDOVER
  } hoc_loop_e;

  typedef struct packed {
    logic             bw_sel;
    logic             ramp_en;
    logic [HOC_NW-1:0] window;
    logic [HOC_NW-1:0] delay;
    logic             force_hold;
  } hoc_loop_cfg_s;

  typedef struct packed {
    logic [HOC_DW-1:0] rdata;
    logic              ready;
    logic              err;
  } hoc_apb_rsp_s;

endpackage

/* hdl/hoc_regs.sv */
// holdover control and status register bank for loops A, C and D
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - status bits show holdover or free-run
// - holdover only with valid history, else free-run
// - sticky flag set on each holdover entry
// - writing zero clears flag; new event wins
// - history-ready bit readable per loop
// - five-bit averaging window length field
// - five-bit history skip delay field
// - force bit drives loop into holdover
// - exit bandwidth: 0 fast, 1 normal
// - enter holdover when no valid input
// - leave holdover when input valid again
// - ramped exit starts ramp toward target
module hoc_regs (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [hoc_pkg::HOC_AW-1:0]  paddr,
  input  wire logic [hoc_pkg::HOC_DW-1:0]  pwdata,
  output logic      [hoc_pkg::HOC_DW-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [hoc_pkg::HOC_LOOPS-1:0] input_ok,
  input  wire logic [hoc_pkg::HOC_LOOPS-1:0] lock_done,
  input  wire logic [hoc_pkg::HOC_LOOPS-1:0] history_full,
  output hoc_pkg::hoc_loop_cfg_s [hoc_pkg::HOC_LOOPS-1:0] loop_cfg,
  output logic      [hoc_pkg::HOC_LOOPS-1:0] loop_holdover,
  output logic      [hoc_pkg::HOC_LOOPS-1:0] loop_fast_bw,
  output logic      [hoc_pkg::HOC_LOOPS-1:0] ramp_start,
  output logic                             irq
);
  import hoc_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  hoc_loop_cfg_s [HOC_LOOPS-1:0] cfg_reg;
  hoc_loop_e                     st_reg   [HOC_LOOPS];
  hoc_loop_e                     st_next  [HOC_LOOPS];
  logic [HOC_LOOPS-1:0]          unsync_reg;
  logic [HOC_LOOPS-1:0]          history_ready_reg;
  logic [HOC_LOOPS-1:0]          sticky_reg;
  logic [HOC_LOOPS-1:0]          mask_reg;
  logic [HOC_LOOPS-1:0]          hold_entry;
  logic [HOC_LOOPS-1:0]          hold_exit;
  logic [HOC_LOOPS-1:0]          holdover_reg;
  logic [HOC_LOOPS-1:0]          fast_bw_reg;
  logic [HOC_LOOPS-1:0]          ramp_reg;
  logic                          irq_reg;
  hoc_apb_rsp_s                  rsp_reg;
  hoc_apb_rsp_s                  rsp_next;
  hoc_idx_t                      idx;
  logic                          wr_go;
  logic                          hit;
  logic [7:0]                    rd_byte;

  assign idx   = paddr[HOC_AW-1:2];
  // a write lands only on the completing edge of the access phase
  assign wr_go = psel & penable & pwrite & rsp_reg.ready;

  // ---------------------------------------------------------------
  // address decode and read mux
  // ---------------------------------------------------------------
  always_comb begin
    hit     = 1'b0;
    rd_byte = 8'h00;
    if (paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (idx == HOC_IDX_STATE) begin
      hit = 1'b1;
      for (int i = 0; i < HOC_LOOPS; i++) rd_byte[HOC_FLD_POS[i]] = unsync_reg[i];
    end else if (idx == HOC_IDX_STICKY) begin
      hit = 1'b1;
      for (int i = 0; i < HOC_LOOPS; i++) rd_byte[HOC_FLD_POS[i]] = sticky_reg[i];
    end else if (idx == HOC_IDX_MASK) begin
      hit = 1'b1;
      for (int i = 0; i < HOC_LOOPS; i++) rd_byte[HOC_FLD_POS[i]] = mask_reg[i];
    end else begin
      for (int i = 0; i < HOC_LOOPS; i++) begin
        if (idx == HOC_IDX_EXIT[i]) begin
          hit = 1'b1;
          rd_byte[HOC_BW_BIT]   = cfg_reg[i].bw_sel;
          rd_byte[HOC_RAMP_BIT] = cfg_reg[i].ramp_en;
        end else if (idx == HOC_IDX_WIN[i]) begin
          hit = 1'b1;
          rd_byte[HOC_NW-1:0] = cfg_reg[i].window;
        end else if (idx == HOC_IDX_DLY[i]) begin
          hit = 1'b1;
          rd_byte[HOC_NW-1:0] = cfg_reg[i].delay;
        end else if (idx == HOC_IDX_FORCE[i]) begin
          hit = 1'b1;
          rd_byte[HOC_FORCE_BIT] = cfg_reg[i].force_hold;
        end else if (idx == HOC_IDX_HIST[i]) begin
          hit = 1'b1;
          rd_byte[HOC_HIST_BIT] = history_ready_reg[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // apb response: one wait state so every bus output is a flop
  // ---------------------------------------------------------------
  always_comb begin
    rsp_next = '0;
    if (psel && penable && !rsp_reg.ready) begin
      rsp_next.ready = 1'b1;
      rsp_next.err   = ~hit;
      rsp_next.rdata = (pwrite || !hit) ? '0 : {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  assign prdata  = rsp_reg.rdata;
  assign pready  = rsp_reg.ready;
  assign pslverr = rsp_reg.err;

  // ---------------------------------------------------------------
  // writable configuration
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < HOC_LOOPS; i++) begin
        cfg_reg[i].bw_sel     <= HOC_BW_RST;
        cfg_reg[i].ramp_en    <= HOC_RAMP_RST;
        cfg_reg[i].window     <= HOC_WIN_RST;
        cfg_reg[i].delay      <= HOC_DLY_RST;
        cfg_reg[i].force_hold <= HOC_FORCE_RST;
      end
    end else if (wr_go) begin
      for (int i = 0; i < HOC_LOOPS; i++) begin
        if (idx == HOC_IDX_EXIT[i]) begin
          cfg_reg[i].bw_sel  <= pwdata[HOC_BW_BIT];
          cfg_reg[i].ramp_en <= pwdata[HOC_RAMP_BIT];
        end else if (idx == HOC_IDX_WIN[i]) begin
          cfg_reg[i].window <= pwdata[HOC_NW-1:0];
        end else if (idx == HOC_IDX_DLY[i]) begin
          cfg_reg[i].delay <= pwdata[HOC_NW-1:0];
        end else if (idx == HOC_IDX_FORCE[i]) begin
          cfg_reg[i].force_hold <= pwdata[HOC_FORCE_BIT];
        end
      end
    end
  end

  assign loop_cfg = cfg_reg;

  // ---------------------------------------------------------------
  // per-loop holdover state machine
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < HOC_LOOPS; g++) begin : gen_loop
      logic lost;
      // a forced or input-less loop drops sync; history picks its fallback
      assign lost = cfg_reg[g].force_hold | ~input_ok[g];

      always_comb begin
        st_next[g] = st_reg[g];
        case (st_reg[g])
          HOC_FREERUN: begin
            if (lost && history_ready_reg[g]) begin
              st_next[g] = HOC_HOLDOVER;
            end else if (!lost) begin
              st_next[g] = HOC_ACQUIRE;
            end
          end
          HOC_ACQUIRE, HOC_LOCKED: begin
            if (lost) begin
              st_next[g] = history_ready_reg[g] ? HOC_HOLDOVER : HOC_FREERUN;
            end else if (st_reg[g] == HOC_ACQUIRE && lock_done[g]) begin
              st_next[g] = HOC_LOCKED;
            end
          end
          HOC_HOLDOVER: begin
            if (!lost) begin
              st_next[g] = HOC_ACQUIRE;
            end
          end
          default: st_next[g] = HOC_FREERUN;
        endcase
      end

      assign hold_entry[g] = (st_next[g] == HOC_HOLDOVER) && (st_reg[g] != HOC_HOLDOVER);
      assign hold_exit[g]  = (st_reg[g] == HOC_HOLDOVER) && (st_next[g] != HOC_HOLDOVER);

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st_reg[g] <= HOC_FREERUN;
        end else begin
          st_reg[g] <= st_next[g];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          unsync_reg[g]   <= 1'b1;
          holdover_reg[g] <= 1'b0;
        end else begin
          unsync_reg[g]   <= (st_next[g] == HOC_FREERUN) || (st_next[g] == HOC_HOLDOVER);
          holdover_reg[g] <= (st_next[g] == HOC_HOLDOVER);
        end
      end

      // fast bandwidth lasts for the reacquisition that follows holdover
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fast_bw_reg[g] <= 1'b0;
          ramp_reg[g]    <= 1'b0;
        end else begin
          ramp_reg[g] <= hold_exit[g] && cfg_reg[g].ramp_en;
          if (hold_exit[g]) begin
            fast_bw_reg[g] <= ~cfg_reg[g].bw_sel;
          end else if (st_next[g] != HOC_ACQUIRE) begin
            fast_bw_reg[g] <= 1'b0;
          end
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          history_ready_reg[g] <= 1'b0;
        end else begin
          history_ready_reg[g] <= history_full[g];
        end
      end

      // sticky event flag: a new entry outweighs a same-cycle clear
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sticky_reg[g] <= 1'b0;
        end else if (hold_entry[g]) begin
          sticky_reg[g] <= 1'b1;
        end else if (wr_go && idx == HOC_IDX_STICKY && !pwdata[HOC_FLD_POS[g]]) begin
          sticky_reg[g] <= 1'b0;
        end
      end

      // ------------------------------------------------------------
      // checks
      // ------------------------------------------------------------
      a_hold_needs_hist: assert property (@(posedge pclk) disable iff (!presetn)
        hold_entry[g] |-> history_ready_reg[g])
        else $error("holdover entered without valid history");
      a_free_no_hist: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg[g] == HOC_LOCKED && !input_ok[g] && !history_ready_reg[g])
        |=> st_reg[g] == HOC_FREERUN && unsync_reg[g])
        else $error("loop without history did not fall to free-run");
      a_auto_enter: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg[g] == HOC_LOCKED && !input_ok[g] && history_ready_reg[g])
        |=> holdover_reg[g] && unsync_reg[g])
        else $error("loop did not enter holdover on input loss");
      a_sticky_entry: assert property (@(posedge pclk) disable iff (!presetn)
        hold_entry[g] |=> sticky_reg[g] ##1 (sticky_reg[g] || $past(wr_go)))
        else $error("sticky flag missed a holdover entry");
      a_sticky_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_go && idx == HOC_IDX_STICKY && !pwdata[HOC_FLD_POS[g]] && !hold_entry[g])
        |=> !sticky_reg[g])
        else $error("writing zero did not clear sticky flag");
      a_force_keeps: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg[g] == HOC_HOLDOVER && cfg_reg[g].force_hold) |=> st_reg[g] == HOC_HOLDOVER)
        else $error("holdover left while force set");
      a_force_enters: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg[g] == HOC_LOCKED && cfg_reg[g].force_hold && history_ready_reg[g])
        |=> holdover_reg[g])
        else $error("force did not drive holdover");
      a_auto_exit: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg[g] == HOC_HOLDOVER && !cfg_reg[g].force_hold && input_ok[g])
        |=> st_reg[g] == HOC_ACQUIRE && !holdover_reg[g])
        else $error("holdover not left on valid input");
      a_exit_bw: assert property (@(posedge pclk) disable iff (!presetn)
        hold_exit[g] |=> fast_bw_reg[g] == !$past(cfg_reg[g].bw_sel))
        else $error("wrong exit bandwidth");
      a_ramp_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        (hold_exit[g] && cfg_reg[g].ramp_en) |=> ramp_reg[g] ##1 !ramp_reg[g])
        else $error("ramp start not a single pulse");
      a_window_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_go && idx == HOC_IDX_WIN[g]) |=> cfg_reg[g].window == $past(pwdata[HOC_NW-1:0]))
        else $error("window length write lost");
      a_hist_follow: assert property (@(posedge pclk) disable iff (!presetn)
        history_ready_reg[g] == $past(history_full[g]))
        else $error("history bit does not follow source");
      a_delay_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_go && idx == HOC_IDX_DLY[g]) |=> cfg_reg[g].delay == $past(pwdata[HOC_NW-1:0]))
        else $error("history delay write lost");
      a_force_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_go && idx == HOC_IDX_FORCE[g])
        |=> cfg_reg[g].force_hold == $past(pwdata[HOC_FORCE_BIT]))
        else $error("force bit write lost");
      a_exit_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_go && idx == HOC_IDX_EXIT[g]) |=> cfg_reg[g].bw_sel == $past(pwdata[HOC_BW_BIT]))
        else $error("exit bandwidth write lost");
      // a set flag must survive every cycle without a write to the sticky register
      a_sticky_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (sticky_reg[g] && !(wr_go && idx == HOC_IDX_STICKY)) |=> sticky_reg[g])
        else $error("sticky flag dropped without a clear");
      a_fast_bw_life: assert property (@(posedge pclk) disable iff (!presetn)
        fast_bw_reg[g] |-> st_reg[g] == HOC_ACQUIRE)
        else $error("fast bandwidth outside reacquisition");
      a_ramp_cause: assert property (@(posedge pclk) disable iff (!presetn)
        ramp_reg[g] |-> $past(hold_exit[g] && cfg_reg[g].ramp_en))
        else $error("ramp start without ramped exit");

      c_hold_cycle: cover property (@(posedge pclk) disable iff (!presetn)
        hold_entry[g] ##[1:50] hold_exit[g]);
      c_freerun_fall: cover property (@(posedge pclk) disable iff (!presetn)
        st_reg[g] == HOC_LOCKED ##1 st_reg[g] == HOC_FREERUN);
      c_clear_race: cover property (@(posedge pclk) disable iff (!presetn)
        hold_entry[g] && wr_go && idx == HOC_IDX_STICKY);
      c_forced_hold: cover property (@(posedge pclk) disable iff (!presetn)
        (st_reg[g] == HOC_LOCKED && cfg_reg[g].force_hold) ##1 st_reg[g] == HOC_HOLDOVER);
    end
  endgenerate

  // ---------------------------------------------------------------
  // mask and interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= HOC_MASK_RST;
    end else if (wr_go && idx == HOC_IDX_MASK) begin
      for (int i = 0; i < HOC_LOOPS; i++) mask_reg[i] <= pwdata[HOC_FLD_POS[i]];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(sticky_reg & mask_reg);
    end
  end

  assign irq           = irq_reg;
  assign loop_holdover = holdover_reg;
  assign loop_fast_bw  = fast_bw_reg;
  assign ramp_start    = ramp_reg;

  // ---------------------------------------------------------------
  // bus and interrupt checks
  // ---------------------------------------------------------------
  a_apb_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_answer: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready)
    else $error("access phase not answered after one wait state");
  // bus outputs rest at zero so a stray sample never sees stale data
  a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> (prdata == '0 && !pslverr))
    else $error("bus outputs not quiet between answers");
  a_err_no_data: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && pslverr) |-> prdata == '0)
    else $error("error answer carried data");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == $past(|(sticky_reg & mask_reg)))
    else $error("interrupt does not follow unmasked flags");
  c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);

endmodule

`default_nettype wire

/* dv/test_pll_holdover_control_regs.sv */
// self-checking bench for the holdover control register bank
`timescale 1ns/1ps
`default_nettype none

module test_pll_holdover_control_regs;
  import hoc_pkg::*;

  logic                          pclk;
  logic                          presetn;
  logic                          psel;
  logic                          penable;
  logic                          pwrite;
  logic [HOC_AW-1:0]             paddr;
  logic [HOC_DW-1:0]             pwdata;
  logic [HOC_DW-1:0]             prdata;
  logic                          pready;
  logic                          pslverr;
  logic [HOC_LOOPS-1:0]          input_ok;
  logic [HOC_LOOPS-1:0]          lock_done;
  logic [HOC_LOOPS-1:0]          history_full;
  hoc_loop_cfg_s [HOC_LOOPS-1:0] loop_cfg;
  logic [HOC_LOOPS-1:0]          loop_holdover;
  logic [HOC_LOOPS-1:0]          loop_fast_bw;
  logic [HOC_LOOPS-1:0]          ramp_start;
  logic                          irq;
  logic [HOC_DW-1:0]             rdv;
  logic                          errv;
  logic [31:0]                   seed;
  int                            mismatches;
  int                            checks_done;

  hoc_regs dut_u (
    .pclk          (pclk),
    .presetn       (presetn),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .input_ok      (input_ok),
    .lock_done     (lock_done),
    .history_full  (history_full),
    .loop_cfg      (loop_cfg),
    .loop_holdover (loop_holdover),
    .loop_fast_bw  (loop_fast_bw),
    .ramp_start    (ramp_start),
    .irq           (irq)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // request held until pready is sampled high; no latency assumed
  task automatic apb(input logic wr, input hoc_idx_t idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdv = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) mismatches++;
  endtask

  task automatic rd_chk(input string name, input hoc_idx_t idx, input logic [31:0] exp,
                        input logic [31:0] mask);
    apb(1'b0, idx, 8'h00);
    chk(name, exp & mask, rdv & mask);
  endtask

  // ---------------------------------------------------------------
  // watchdog: whole run needs well under 3000 cycles
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    print_verdict();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int   p;
    logic bw;
    mismatches = 0;
    checks_done = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    input_ok = '0;
    lock_done = '0;
    history_full = '0;
    seed = 32'h0000CE37;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("state reset", HOC_IDX_STATE, 32'h000000D0, 32'h000000F0);
    rd_chk("sticky reset", HOC_IDX_STICKY, 32'h0, 32'h000000F0);
    apb(1'b0, 14'h0001, 8'h00);
    chk("unmapped error", 32'h1, {31'h0, errv});
    chk("unmapped data", 32'h0, rdv);
    for (int i = 0; i < HOC_LOOPS; i++) begin
      rd_chk("exit reset", HOC_IDX_EXIT[i], 32'h08, 32'h18);
      rd_chk("window reset", HOC_IDX_WIN[i], 32'h0A, 32'h1F);
      rd_chk("delay reset", HOC_IDX_DLY[i], 32'h00, 32'h1F);
      rd_chk("force reset", HOC_IDX_FORCE[i], 32'h00, 32'h01);
      seed = lfsr(seed);
      // delay field of loop A gets the all-ones corner
      seed[12:8] = (i == 0) ? 5'h1F : seed[12:8];
      apb(1'b1, HOC_IDX_WIN[i], {3'h0, seed[4:0]});
      apb(1'b1, HOC_IDX_DLY[i], {3'h0, seed[12:8]});
      rd_chk("window", HOC_IDX_WIN[i], {27'h0, seed[4:0]}, 32'h1F);
      rd_chk("delay", HOC_IDX_DLY[i], {27'h0, seed[12:8]}, 32'h1F);
      chk("cfg window", {27'h0, seed[4:0]}, {27'h0, loop_cfg[i].window});
      chk("cfg delay", {27'h0, seed[12:8]}, {27'h0, loop_cfg[i].delay});
      apb(1'b1, HOC_IDX_HIST[i], 8'hFF);
      rd_chk("history ro", HOC_IDX_HIST[i], 32'h0, 32'h02);
    end
    for (int i = 0; i < HOC_LOOPS; i++) begin
      p = HOC_FLD_POS[i];
      bw = (i == 1);
      apb(1'b1, HOC_IDX_MASK, 8'h01 << p);
      @(posedge pclk);
      input_ok[i] <= 1'b1;
      history_full[i] <= 1'b1;
      repeat (3) @(posedge pclk);
      rd_chk("state acquire", HOC_IDX_STATE, 32'h0, 32'h1 << p);
      rd_chk("history ready", HOC_IDX_HIST[i], 32'h2, 32'h2);
      @(posedge pclk);
      lock_done[i] <= 1'b1;
      @(posedge pclk);
      lock_done[i] <= 1'b0;
      input_ok[i] <= 1'b0;
      @(posedge pclk);
      #1;
      chk("holdover entry", 32'h1, {31'h0, loop_holdover[i]});
      @(posedge pclk);
      #1;
      chk("irq raised", 32'h1, {31'h0, irq});
      rd_chk("state hold", HOC_IDX_STATE, 32'h1 << p, 32'h1 << p);
      rd_chk("sticky set", HOC_IDX_STICKY, 32'h1 << p, 32'h1 << p);
      apb(1'b1, HOC_IDX_STICKY, ~(8'h01 << p));
      rd_chk("sticky clear", HOC_IDX_STICKY, 32'h0, 32'h1 << p);
      chk("irq cleared", 32'h0, {31'h0, irq});
      apb(1'b1, HOC_IDX_EXIT[i], {3'h0, bw, 1'b1, 3'h0});
      @(posedge pclk);
      input_ok[i] <= 1'b1;
      @(posedge pclk);
      #1;
      chk("holdover exit", 32'h0, {31'h0, loop_holdover[i]});
      chk("ramp pulse", 32'h1, {31'h0, ramp_start[i]});
      chk("fast bandwidth", {31'h0, !bw}, {31'h0, loop_fast_bw[i]});
      @(posedge pclk);
      #1;
      chk("ramp end", 32'h0, {31'h0, ramp_start[i]});
      @(posedge pclk);
      lock_done[i] <= 1'b1;
      @(posedge pclk);
      lock_done[i] <= 1'b0;
      #1;
      chk("fast bw after lock", 32'h0, {31'h0, loop_fast_bw[i]});
      // mask off: forced entry must set the flag but keep irq low
      apb(1'b1, HOC_IDX_MASK, 8'h00);
      apb(1'b1, HOC_IDX_FORCE[i], 8'h01);
      repeat (4) @(posedge pclk);
      #1;
      chk("forced hold", 32'h1, {31'h0, loop_holdover[i]});
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, HOC_IDX_STICKY, 8'hFF);
      rd_chk("sticky kept", HOC_IDX_STICKY, 32'h1 << p, 32'h1 << p);
      apb(1'b1, HOC_IDX_FORCE[i], 8'h00);
      repeat (2) @(posedge pclk);
      #1;
      chk("force released", 32'h0, {31'h0, loop_holdover[i]});
      apb(1'b1, HOC_IDX_STICKY, 8'h00);
      @(posedge pclk);
      history_full[i] <= 1'b0;
      lock_done[i] <= 1'b1;
      @(posedge pclk);
      lock_done[i] <= 1'b0;
      repeat (2) @(posedge pclk);
      input_ok[i] <= 1'b0;
      repeat (2) @(posedge pclk);
      #1;
      chk("no history hold", 32'h0, {31'h0, loop_holdover[i]});
      rd_chk("free run state", HOC_IDX_STATE, 32'h1 << p, 32'h1 << p);
      rd_chk("no sticky", HOC_IDX_STICKY, 32'h0, 32'h1 << p);
    end
    print_verdict();
  end

endmodule

`default_nettype wire
